// ==== rtc_pkg.sv ====
// Shared constants, field layouts and carrier types for the clock core
package rtc_pkg;

   // Crystal edges per second for each crystal choice
   localparam int unsigned XTAL_DIV_STD = 32768;
   localparam int unsigned XTAL_DIV_ALT = 32000;
   localparam int unsigned PHASE_W      = 16;

   typedef logic [3:0] reg_addr_t;
   typedef logic [7:0] bcd_t;

   // Register offsets
   localparam reg_addr_t ADDR_SEC   = 4'h0;
   localparam reg_addr_t ADDR_MIN   = 4'h1;
   localparam reg_addr_t ADDR_HOUR  = 4'h2;
   localparam reg_addr_t ADDR_WDAY  = 4'h3;
   localparam reg_addr_t ADDR_DAY   = 4'h4;
   localparam reg_addr_t ADDR_MON   = 4'h5;
   localparam reg_addr_t ADDR_YEAR  = 4'h6;
   localparam reg_addr_t ADDR_TRIM  = 4'h7;
   localparam reg_addr_t ADDR_CTRL1 = 4'he;
   localparam reg_addr_t ADDR_CTRL2 = 4'hf;

   // Implemented bits of each counter register except the weekday
   localparam bcd_t MASK_SEC  = 8'h7f;
   localparam bcd_t MASK_MIN  = 8'h7f;
   localparam bcd_t MASK_HOUR = 8'h3f;
   localparam bcd_t MASK_DAY  = 8'h3f;
   localparam bcd_t MASK_MON  = 8'h1f;
   localparam bcd_t MASK_YEAR = 8'hff;

   // Control register 2 bit positions
   localparam int unsigned C2_HOUR24  = 5;
   localparam int unsigned C2_HALT    = 4;
   localparam int unsigned C2_CLKDIS  = 3;
   localparam int unsigned C2_PERIOD  = 2;
   localparam int unsigned C2_ALARM_A = 1;
   localparam int unsigned C2_ALARM_B = 0;

   // Control register 1 bit positions
   localparam int unsigned C1_ALA_EN  = 7;
   localparam int unsigned C1_ALB_EN  = 6;
   localparam int unsigned C1_ROUTE1  = 5;
   localparam int unsigned C1_ROUTE2  = 4;
   localparam int unsigned C1_TEST    = 3;
   localparam int unsigned C1_PSEL_HI = 2;
   localparam int unsigned C1_PSEL_LO = 0;

   // Trim register: crystal choice bit
   localparam int unsigned TRIM_XTAL_SEL = 7;

   // Periodic cycle select codes
   localparam logic [2:0] PSEL_OFF   = 3'h0;
   localparam logic [2:0] PSEL_LOW   = 3'h1;
   localparam logic [2:0] PSEL_2HZ   = 3'h2;
   localparam logic [2:0] PSEL_1HZ   = 3'h3;
   localparam logic [2:0] PSEL_SEC   = 3'h4;
   localparam logic [2:0] PSEL_MIN   = 3'h5;
   localparam logic [2:0] PSEL_HOUR  = 3'h6;
   localparam logic [2:0] PSEL_MONTH = 3'h7;

   // BCD landmarks of the carry chain
   localparam bcd_t BCD_ZERO   = 8'h00;
   localparam bcd_t BCD_ONE    = 8'h01;
   localparam bcd_t BCD_59     = 8'h59;
   localparam bcd_t BCD_23     = 8'h23;
   localparam bcd_t BCD_AM11   = 8'h11;
   localparam bcd_t BCD_AM12   = 8'h12;
   localparam bcd_t BCD_PM12   = 8'h32;
   localparam bcd_t BCD_PM1    = 8'h21;
   localparam bcd_t BCD_PM11   = 8'h31;
   localparam bcd_t BCD_FEB    = 8'h02;
   localparam bcd_t BCD_APR    = 8'h04;
   localparam bcd_t BCD_JUN    = 8'h06;
   localparam bcd_t BCD_SEP    = 8'h09;
   localparam bcd_t BCD_NOV    = 8'h11;
   localparam bcd_t BCD_DEC    = 8'h12;
   localparam bcd_t BCD_D28    = 8'h28;
   localparam bcd_t BCD_D29    = 8'h29;
   localparam bcd_t BCD_D30    = 8'h30;
   localparam bcd_t BCD_D31    = 8'h31;
   localparam bcd_t BCD_99     = 8'h99;
   localparam logic [3:0] BCD_NINE  = 4'h9;
   localparam logic [2:0] WDAY_LAST = 3'h6;

   // One register write from the serial-bus front end
   typedef struct packed {
      logic      wr;
      reg_addr_t addr;
      bcd_t      wdata;
   } reg_req_t;

endpackage

// ==== rtc_sync2.sv ====
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/10ps
module rtc_sync2 #(
   parameter int unsigned WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clock_i,
   input  wire logic             rst_n_i,
   // Levels
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         meta   <= '0;
         sync_o <= '0;
      end else begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end
endmodule

// ==== rtc_prescaler.sv ====
// Crystal edge divider giving the one-second tick and pulse-mode phases
`timescale 1ns/10ps
module rtc_prescaler
   import rtc_pkg::*;
#(
   parameter int unsigned DIV_STD = XTAL_DIV_STD,
   parameter int unsigned DIV_ALT = XTAL_DIV_ALT
) (
   // Clock and reset
   input  wire logic clock_i,
   input  wire logic rst_n_i,
   // Crystal edge and crystal choice
   input  wire logic xtal_rise_i,
   input  wire logic alt_sel_i,
   // Timing outputs
   output logic      tick_o,
   output logic      low_1hz_o,
   output logic      low_2hz_o
);
   logic [PHASE_W-1:0] phase;
   logic [PHASE_W-1:0] period;
   logic [PHASE_W-1:0] half;
   logic [PHASE_W-1:0] quarter;

   assign period  = alt_sel_i ? PHASE_W'(DIV_ALT - 1) : PHASE_W'(DIV_STD - 1);
   assign half    = PHASE_W'(({1'b0, period} + 1'b1) >> 1);
   assign quarter = PHASE_W'(({1'b0, period} + 1'b1) >> 2);

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         phase <= '0;
      end else if (xtal_rise_i) begin
         phase <= (phase >= period) ? '0 : phase + 1'b1;
      end
   end

   // Seconds count on the edge that closes the period
   assign tick_o    = xtal_rise_i && (phase >= period);
   assign low_1hz_o = phase < half;
   assign low_2hz_o = (phase < quarter) ||
                      ((phase >= half) && (phase < half + quarter));
endmodule

// ==== rtc_core.sv ====
// Timekeeping core: status flags, interrupt pins and BCD calendar
`timescale 1ns/10ps
module rtc_core
   import rtc_pkg::*;
#(
   parameter int unsigned DIV_STD = XTAL_DIV_STD,
   parameter int unsigned DIV_ALT = XTAL_DIV_ALT
) (
   // Clock and reset
   input  wire logic     clock_i,
   input  wire logic     rst_n_i,
   // Register port
   input  wire reg_req_t reg_req_i,
   input  wire reg_addr_t reg_raddr_i,
   output bcd_t          reg_rdata_o,
   // Oscillator side, asynchronous
   input  wire logic     xtal_i,
   input  wire logic     osc_stopped_i,
   // Alarm comparators, same clock
   input  wire logic     alarm_a_match_i,
   input  wire logic     alarm_b_match_i,
   // Open-drain interrupt pins
   output logic          irq_out_a_o,
   output logic          irq_out_a_oe_o,
   output logic          irq_out_b_o,
   output logic          irq_out_b_oe_o
);

   function automatic bcd_t bcd_inc(input bcd_t v);
      if (v[3:0] == BCD_NINE) begin
         bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
         bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
   endfunction

   // Years 00, 04 .. 96: even tens need 0/4/8, odd tens need 2/6
   function automatic logic is_leap(input bcd_t y);
      if (y[4]) begin
         is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      end else begin
         is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) ||
                   (y[3:0] == 4'h8);
      end
   endfunction

   function automatic bcd_t last_day(input bcd_t m, input logic leap);
      if (m == BCD_FEB) begin
         last_day = leap ? BCD_D29 : BCD_D28;
      end else if ((m == BCD_APR) || (m == BCD_JUN) ||
                   (m == BCD_SEP) || (m == BCD_NOV)) begin
         last_day = BCD_D30;
      end else begin
         last_day = BCD_D31;
      end
   endfunction

   function automatic bcd_t hour_inc(input bcd_t h, input logic h24);
      if (h24) begin
         hour_inc = (h == BCD_23) ? BCD_ZERO : bcd_inc(h);
      end else begin
         case (h)
            BCD_AM12: hour_inc = BCD_ONE;
            BCD_AM11: hour_inc = BCD_PM12;
            BCD_PM12: hour_inc = BCD_PM1;
            BCD_PM11: hour_inc = BCD_AM12;
            default:  hour_inc = bcd_inc(h);
         endcase
      end
   endfunction

   // Synchronised oscillator inputs
   logic [1:0] sync_out;
   logic       xtal_s;
   logic       xtal_d;
   logic       osc_stop_s;
   logic       xtal_rise;

   rtc_sync2 #(
      .WIDTH   (2)
   ) u_sync (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .async_i ({xtal_i, osc_stopped_i}),
      .sync_o  (sync_out)
   );

   assign xtal_s     = sync_out[1];
   assign osc_stop_s = sync_out[0];

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         xtal_d <= 1'b0;
      end else begin
         xtal_d <= xtal_s;
      end
   end

   assign xtal_rise = xtal_s && !xtal_d;

   // Register state
   bcd_t       sec;
   bcd_t       min;
   bcd_t       hour;
   logic [2:0] wday;
   bcd_t       day;
   bcd_t       mon;
   bcd_t       year;
   bcd_t       trim;
   bcd_t       ctrl1;
   logic       hour24;
   logic       clkout_disable;
   logic       osc_halt_flag;
   logic       periodic_irq_flag;
   logic       alarm_a_flag;
   logic       alarm_b_flag;

   logic       alarm_a_enable;
   logic       alarm_b_enable;
   logic       route_sel_one;
   logic       route_sel_two;
   logic [2:0] periodic_sel;

   assign alarm_a_enable = ctrl1[C1_ALA_EN];
   assign alarm_b_enable = ctrl1[C1_ALB_EN];
   assign route_sel_one  = ctrl1[C1_ROUTE1];
   assign route_sel_two  = ctrl1[C1_ROUTE2];
   assign periodic_sel   = ctrl1[C1_PSEL_HI:C1_PSEL_LO];

   // Write strobes
   logic wr_sec;
   logic wr_min;
   logic wr_hour;
   logic wr_wday;
   logic wr_day;
   logic wr_mon;
   logic wr_year;
   logic wr_ctrl2;
   bcd_t wd;

   assign wd       = reg_req_i.wdata;
   assign wr_sec   = reg_req_i.wr && (reg_req_i.addr == ADDR_SEC);
   assign wr_min   = reg_req_i.wr && (reg_req_i.addr == ADDR_MIN);
   assign wr_hour  = reg_req_i.wr && (reg_req_i.addr == ADDR_HOUR);
   assign wr_wday  = reg_req_i.wr && (reg_req_i.addr == ADDR_WDAY);
   assign wr_day   = reg_req_i.wr && (reg_req_i.addr == ADDR_DAY);
   assign wr_mon   = reg_req_i.wr && (reg_req_i.addr == ADDR_MON);
   assign wr_year  = reg_req_i.wr && (reg_req_i.addr == ADDR_YEAR);
   assign wr_ctrl2 = reg_req_i.wr && (reg_req_i.addr == ADDR_CTRL2);

   // One-second base
   logic tick;
   logic low_1hz;
   logic low_2hz;

   rtc_prescaler #(
      .DIV_STD     (DIV_STD),
      .DIV_ALT     (DIV_ALT)
   ) u_prescaler (
      .clock_i     (clock_i),
      .rst_n_i     (rst_n_i),
      .xtal_rise_i (xtal_rise),
      .alt_sel_i   (trim[TRIM_XTAL_SEL]),
      .tick_o      (tick),
      .low_1hz_o   (low_1hz),
      .low_2hz_o   (low_2hz)
   );

   // Carry chain; a host write to a counter suppresses its own step
   logic sec_wrap;
   logic min_wrap;
   logic hour_wrap;
   logic day_wrap;
   logic mon_wrap;

   assign sec_wrap  = tick && (sec == BCD_59);
   assign min_wrap  = sec_wrap && (min == BCD_59);
   assign hour_wrap = min_wrap &&
                      (hour24 ? (hour == BCD_23)
                              : (hour == BCD_PM11));
   assign day_wrap  = hour_wrap &&
                      (day == last_day(mon, is_leap(year)));
   assign mon_wrap  = day_wrap && (mon == BCD_DEC);

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         sec <= BCD_ZERO;
      end else if (wr_sec) begin
         sec <= wd & MASK_SEC;
      end else if (tick) begin
         sec <= sec_wrap ? BCD_ZERO : bcd_inc(sec);
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         min <= BCD_ZERO;
      end else if (wr_min) begin
         min <= wd & MASK_MIN;
      end else if (sec_wrap) begin
         min <= min_wrap ? BCD_ZERO : bcd_inc(min);
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         hour <= BCD_ZERO;
      end else if (wr_hour) begin
         hour <= wd & MASK_HOUR;
      end else if (min_wrap) begin
         hour <= hour_inc(hour, hour24);
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         wday <= '0;
      end else if (wr_wday) begin
         wday <= wd[2:0];
      end else if (hour_wrap) begin
         wday <= (wday == WDAY_LAST) ? 3'h0 : wday + 3'h1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         day <= BCD_ONE;
      end else if (wr_day) begin
         day <= wd & MASK_DAY;
      end else if (hour_wrap) begin
         day <= day_wrap ? BCD_ONE : bcd_inc(day);
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         mon <= BCD_ONE;
      end else if (wr_mon) begin
         mon <= wd & MASK_MON;
      end else if (day_wrap) begin
         mon <= mon_wrap ? BCD_ONE : bcd_inc(mon);
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         year <= BCD_ZERO;
      end else if (wr_year) begin
         year <= wd & MASK_YEAR;
      end else if (mon_wrap) begin
         year <= (year == BCD_99) ? BCD_ZERO : bcd_inc(year);
      end
   end

   // Oscillator halt flag; a stop seen in the clearing cycle wins
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         osc_halt_flag <= 1'b1;
      end else if (osc_stop_s) begin
         osc_halt_flag <= 1'b1;
      end else if (wr_ctrl2) begin
         osc_halt_flag <= 1'b0;
      end
   end

   // Control fields other than the hour format held at zero for as long as the halt flag stands
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         trim  <= '0;
         ctrl1 <= '0;
      end else if (osc_halt_flag) begin
         trim  <= '0;
         ctrl1 <= '0;
      end else if (reg_req_i.wr) begin
         if (reg_req_i.addr == ADDR_TRIM) begin
            trim <= wd;
         end
         if (reg_req_i.addr == ADDR_CTRL1) begin
            ctrl1 <= wd;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         hour24         <= 1'b0;
         clkout_disable <= 1'b0;
      end else begin
         if (wr_ctrl2) begin
            hour24 <= wd[C2_HOUR24];
         end
         if (osc_halt_flag) begin
            clkout_disable <= 1'b0;
         end else if (wr_ctrl2) begin
            clkout_disable <= wd[C2_CLKDIS];
         end
      end
   end

   // Periodic flag follows the output waveform; level mode latches
   logic level_event;
   logic per_clear;

   always_comb begin
      case (periodic_sel)
         PSEL_SEC:   level_event = tick;
         PSEL_MIN:   level_event = sec_wrap;
         PSEL_HOUR:  level_event = min_wrap;
         PSEL_MONTH: level_event = day_wrap;
         default:    level_event = 1'b0;
      endcase
   end

   assign per_clear = wr_ctrl2 && !wd[C2_PERIOD];

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         periodic_irq_flag <= 1'b0;
      end else begin
         case (periodic_sel)
            PSEL_OFF: periodic_irq_flag <= 1'b0;
            PSEL_LOW: periodic_irq_flag <= 1'b1;
            PSEL_2HZ: periodic_irq_flag <= low_2hz;
            PSEL_1HZ: periodic_irq_flag <= low_1hz;
            default: begin
               if (level_event) begin
                  periodic_irq_flag <= 1'b1;
               end else if (per_clear) begin
                  periodic_irq_flag <= 1'b0;
               end
            end
         endcase
      end
   end

   // Alarm flags; a match in the clearing cycle wins over the clear
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         alarm_a_flag <= 1'b0;
      end else if (!alarm_a_enable) begin
         alarm_a_flag <= 1'b0;
      end else if (alarm_a_match_i) begin
         alarm_a_flag <= 1'b1;
      end else if (wr_ctrl2 && !wd[C2_ALARM_A]) begin
         alarm_a_flag <= 1'b0;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         alarm_b_flag <= 1'b0;
      end else if (!alarm_b_enable) begin
         alarm_b_flag <= 1'b0;
      end else if (alarm_b_match_i) begin
         alarm_b_flag <= 1'b1;
      end else if (wr_ctrl2 && !wd[C2_ALARM_B]) begin
         alarm_b_flag <= 1'b0;
      end
   end

   // Pin routing; control fields are already zero while halted
   logic a_on;
   logic b_on;
   logic clk_low;

   assign clk_low = !clkout_disable && !xtal_s;
   assign a_on = !osc_halt_flag &&
                 (alarm_a_flag ||
                  (!route_sel_two && alarm_b_flag) ||
                  (!route_sel_one && periodic_irq_flag));
   assign b_on = clk_low ||
                 (route_sel_two && alarm_b_flag) ||
                 (route_sel_one && periodic_irq_flag);

   // Open drain: the pin is pulled low only while enabled
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         irq_out_a_o    <= 1'b0;
         irq_out_a_oe_o <= 1'b0;
         irq_out_b_o    <= 1'b0;
         irq_out_b_oe_o <= 1'b0;
      end else begin
         irq_out_a_o    <= 1'b0;
         irq_out_a_oe_o <= a_on;
         irq_out_b_o    <= 1'b0;
         irq_out_b_oe_o <= b_on;
      end
   end

   // Read data, one cycle behind the address
   bcd_t next_rdata;

   always_comb begin
      case (reg_raddr_i)
         ADDR_SEC:   next_rdata = sec;
         ADDR_MIN:   next_rdata = min;
         ADDR_HOUR:  next_rdata = hour;
         ADDR_WDAY:  next_rdata = {5'h00, wday};
         ADDR_DAY:   next_rdata = day;
         ADDR_MON:   next_rdata = mon;
         ADDR_YEAR:  next_rdata = year;
         ADDR_TRIM:  next_rdata = trim;
         ADDR_CTRL1: next_rdata = ctrl1;
         ADDR_CTRL2: begin
            next_rdata = '0;
            next_rdata[C2_HOUR24]  = hour24;
            next_rdata[C2_HALT]    = osc_halt_flag;
            next_rdata[C2_CLKDIS]  = clkout_disable;
            next_rdata[C2_PERIOD]  = periodic_irq_flag;
            next_rdata[C2_ALARM_A] = alarm_a_flag && alarm_a_enable;
            next_rdata[C2_ALARM_B] = alarm_b_flag && alarm_b_enable;
         end
         default:    next_rdata = '0;
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= '0;
      end else begin
         reg_rdata_o <= next_rdata;
      end
   end

endmodule

// ==== rtc_core_asserts.sv ====
// Port-level assertions for the clock core
`timescale 1ns/10ps
module rtc_core_asserts
   import rtc_pkg::*;
(
   // Clock and reset
   input wire logic      clock_i,
   input wire logic      rst_n_i,
   // Register port
   input wire reg_req_t  reg_req_i,
   input wire reg_addr_t reg_raddr_i,
   input wire bcd_t      reg_rdata_o,
   // Oscillator and alarm inputs
   input wire logic      xtal_i,
   input wire logic      osc_stopped_i,
   input wire logic      alarm_a_match_i,
   input wire logic      alarm_b_match_i,
   // Interrupt pins
   input wire logic      irq_out_a_o,
   input wire logic      irq_out_a_oe_o,
   input wire logic      irq_out_b_o,
   input wire logic      irq_out_b_oe_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   sequence fmt_wr_s;
      reg_req_i.wr && reg_req_i.addr == ADDR_CTRL2 && reg_req_i.wdata[5];
   endsequence
   sequence ctrl2_rd_s;
      reg_raddr_i == ADDR_CTRL2 && !reg_req_i.wr;
   endsequence

   sec_bcd_range_a: assert property (reg_raddr_i == ADDR_SEC |=>
      reg_rdata_o[7] == 1'b0 && reg_rdata_o[3:0] <= 4'h9)
      else $error("seconds read outside BCD range");
   min_bcd_range_a: assert property (reg_raddr_i == ADDR_MIN |=>
      reg_rdata_o <= 8'h59 && reg_rdata_o[3:0] <= 4'h9)
      else $error("minutes read outside BCD range");
   hour_top_bits_a: assert property (reg_raddr_i == ADDR_HOUR |=>
      reg_rdata_o[7:6] == 2'h0 && reg_rdata_o[3:0] <= 4'h9)
      else $error("hours read with bad bits");
   weekday_range_a: assert property (reg_raddr_i == ADDR_WDAY |=>
      reg_rdata_o[7:3] == 5'h00 && reg_rdata_o[2:0] != 3'h7)
      else $error("weekday read out of range");
   day_range_a: assert property (reg_raddr_i == ADDR_DAY |=>
      reg_rdata_o >= 8'h01 && reg_rdata_o <= 8'h31)
      else $error("day read out of range");
   month_range_a: assert property (reg_raddr_i == ADDR_MON |=>
      reg_rdata_o >= 8'h01 && reg_rdata_o <= 8'h12)
      else $error("month read out of range");
   unmapped_zero_a: assert property (
      reg_raddr_i inside {[4'h8:4'hd]} |=> reg_rdata_o == 8'h00)
      else $error("unmapped address read nonzero");
   ctrl2_top_zero_a: assert property (
      reg_raddr_i == ADDR_CTRL2 |=> reg_rdata_o[7:6] == 2'h0)
      else $error("control two upper bits nonzero");
   pin_data_low_a: assert property (
      irq_out_a_o == 1'b0 && irq_out_b_o == 1'b0)
      else $error("open-drain data not low");
   hour_format_a: assert property (fmt_wr_s ##1 ctrl2_rd_s |=>
      reg_rdata_o[5])
      else $error("hour format bit not stored");
   halt_on_stop_a: assert property (
      osc_stopped_i [*4] ##1 ctrl2_rd_s |=> reg_rdata_o[4])
      else $error("halt flag clear while stopped");
   pin_a_halt_a: assert property (
      osc_stopped_i [*8] |-> !irq_out_a_oe_o)
      else $error("pin a pulled while halted");
endmodule

bind rtc_core rtc_core_asserts chk (.clock_i, .rst_n_i, .reg_req_i,
   .reg_raddr_i, .reg_rdata_o, .xtal_i, .osc_stopped_i, .alarm_a_match_i,
   .alarm_b_match_i, .irq_out_a_o, .irq_out_a_oe_o, .irq_out_b_o,
   .irq_out_b_oe_o);

// ==== rtc_xtal_model.sv ====
// Crystal oscillator stand-in feeding the clock core
`timescale 1ns/10ps
module rtc_xtal_model #(
   parameter int unsigned HALF = 4
) (
   // Clock
   input  wire logic clock_i,
   // Oscillation control
   input  wire logic run_i,
   // Oscillator side
   output logic      xtal_o,
   output logic      stopped_o
);
   int unsigned cnt = 0;
   initial xtal_o = 1'b0;
   // A halted crystal stands still, so no edges reach the divider
   always @(posedge clock_i) begin
      if (run_i) begin
         cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
         if (cnt == HALF - 1) begin
            xtal_o <= ~xtal_o;
         end
      end
   end
   assign stopped_o = ~run_i;
endmodule

// ==== rtc_core_bench.sv ====
// Self-checking bench for the clock core
`timescale 1ns/10ps
module rtc_core_bench;
   import rtc_pkg::*;
   logic      clock_i     = 1'b0;
   logic      rst_n_i     = 1'b0;
   reg_req_t  reg_req_i   = '0;
   reg_addr_t reg_raddr_i = '0;
   bcd_t      reg_rdata_o;
   logic      xtal, stopped, oe_a, oe_b;
   logic      run         = 1'b1;
   logic      al_a        = 1'b0;
   logic      al_b        = 1'b0;
   int        error_cnt   = 0;
   int        checked     = 0;
   int        hi_a, hi_b;

   always #20 clock_i = ~clock_i;

   rtc_xtal_model xm (.clock_i(clock_i), .run_i(run), .xtal_o(xtal),
      .stopped_o(stopped));
   // Short divider keeps a second at 64 system cycles, 48 with the alternate crystal
   rtc_core #(.DIV_STD(8), .DIV_ALT(6)) dut (.clock_i(clock_i),
      .rst_n_i(rst_n_i), .reg_req_i(reg_req_i), .reg_raddr_i(reg_raddr_i),
      .reg_rdata_o(reg_rdata_o), .xtal_i(xtal), .osc_stopped_i(stopped),
      .alarm_a_match_i(al_a), .alarm_b_match_i(al_b), .irq_out_a_o(),
      .irq_out_a_oe_o(oe_a), .irq_out_b_o(), .irq_out_b_oe_o(oe_b));

   task automatic check(input string what, input bcd_t seen, input bcd_t exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input reg_addr_t a, input bcd_t d);
      @(posedge clock_i);
      reg_req_i <= '{wr: 1'b1, addr: a, wdata: d};
      @(posedge clock_i);
      reg_req_i.wr <= 1'b0;
   endtask
   task automatic rd(input reg_addr_t a, output bcd_t d);
      @(posedge clock_i);
      reg_raddr_i <= a;
      @(posedge clock_i);
      #1 d = reg_rdata_o;
   endtask
   task automatic rdc(input string what, input reg_addr_t a, input bcd_t e);
      bcd_t v;
      rd(a, v);
      check(what, v, e);
   endtask
   task automatic pins(input int n);
      hi_a = 0;
      hi_b = 0;
      repeat (n) begin
         @(posedge clock_i);
         #1;
         hi_a += oe_a;
         hi_b += oe_b;
      end
   endtask
   task automatic osc(input logic on);
      @(posedge clock_i);
      run <= on;
      repeat (6) @(posedge clock_i);
   endtask
   task automatic pulse(input logic b);
      @(posedge clock_i);
      if (b) al_b <= 1'b1;
      else al_a <= 1'b1;
      @(posedge clock_i);
      al_a <= 1'b0;
      al_b <= 1'b0;
      repeat (3) @(posedge clock_i);
   endtask
   // Time is parked one second before midnight or an hour edge
   task automatic roll(input bcd_t f, h, mo, d, y, eh, ed, emo, ey);
      bcd_t v;
      int   n;
      wr(ADDR_CTRL2, f);
      wr(ADDR_HOUR, h);
      wr(ADDR_YEAR, y);
      wr(ADDR_MON, mo);
      wr(ADDR_DAY, d);
      wr(ADDR_WDAY, 8'h06);
      wr(ADDR_MIN, 8'h59);
      wr(ADDR_SEC, 8'h59);
      n = 0;
      v = 8'h59;
      while (v !== 8'h00 && n < 200) begin
         rd(ADDR_SEC, v);
         n++;
      end
      check("second", v, 8'h00);
      rdc("minute", ADDR_MIN, 8'h00);
      rdc("hour", ADDR_HOUR, eh);
      v = (ed != d) ? 8'h00 : 8'h06;
      rdc("weekday", ADDR_WDAY, v);
      rdc("day", ADDR_DAY, ed);
      rdc("month", ADDR_MON, emo);
      rdc("year", ADDR_YEAR, ey);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clock_i);
      error_cnt++;
      final_report();
   end

   initial begin
      repeat (3) @(posedge clock_i);
      rst_n_i <= 1'b1;
      rdc("ctrl2 reset", ADDR_CTRL2, 8'h10);
      rdc("day reset", ADDR_DAY, 8'h01);
      wr(ADDR_CTRL1, 8'hff);
      rdc("ctrl1 halted", ADDR_CTRL1, 8'h00);
      pins(40);
      check("pin a idle", 8'(hi_a), 8'h00);
      check("pin b clock", {7'h00, hi_b != 0}, 8'h01);
      osc(1'b0);
      wr(ADDR_CTRL2, 8'h00);
      rdc("halt kept", ADDR_CTRL2, 8'h10);
      osc(1'b1);
      wr(ADDR_CTRL2, 8'h00);
      rdc("halt cleared", ADDR_CTRL2, 8'h00);
      wr(ADDR_TRIM, 8'h80);
      wr(ADDR_CTRL1, 8'hc6);
      rdc("trim", ADDR_TRIM, 8'h80);
      wr(ADDR_CTRL2, 8'h08);
      rdc("clkout off", ADDR_CTRL2, 8'h08);
      pins(40);
      check("pin b quiet", 8'(hi_b), 8'h00);
      wr(ADDR_CTRL2, 8'h00);
      pins(40);
      check("pin b on", {7'h00, hi_b != 0}, 8'h01);
      osc(1'b0);
      rdc("trim forced", ADDR_TRIM, 8'h00);
      rdc("ctrl1 forced", ADDR_CTRL1, 8'h00);
      osc(1'b1);
      wr(ADDR_CTRL2, 8'h00);
      wr(ADDR_CTRL1, 8'hc6);
      $display("test halt done");
      roll(8'h20,8'h23,8'h01,8'h28,8'h00,8'h00,8'h29,8'h01,8'h00);
      roll(8'h20,8'h23,8'h04,8'h30,8'h01,8'h00,8'h01,8'h05,8'h01);
      roll(8'h20,8'h23,8'h02,8'h28,8'h04,8'h00,8'h29,8'h02,8'h04);
      roll(8'h20,8'h23,8'h02,8'h28,8'h01,8'h00,8'h01,8'h03,8'h01);
      roll(8'h00,8'h31,8'h01,8'h05,8'h00,8'h12,8'h06,8'h01,8'h00);
      roll(8'h00,8'h11,8'h01,8'h05,8'h00,8'h32,8'h05,8'h01,8'h00);
      roll(8'h20,8'h23,8'h12,8'h31,8'h99,8'h00,8'h01,8'h01,8'h00);
      $display("test calendar done");
      rdc("periodic set", ADDR_CTRL2, 8'h24);
      check("pin a periodic", {7'h00, oe_a}, 8'h01);
      wr(ADDR_CTRL2, 8'h24);
      rdc("periodic one", ADDR_CTRL2, 8'h24);
      wr(ADDR_CTRL2, 8'h20);
      rdc("periodic clr", ADDR_CTRL2, 8'h20);
      check("pin a released", {7'h00, oe_a}, 8'h00);
      pulse(1'b0);
      rdc("alarm a set", ADDR_CTRL2, 8'h22);
      check("pin a alarm", {7'h00, oe_a}, 8'h01);
      wr(ADDR_CTRL2, 8'h22);
      rdc("alarm a one", ADDR_CTRL2, 8'h22);
      wr(ADDR_CTRL2, 8'h20);
      rdc("alarm a clr", ADDR_CTRL2, 8'h20);
      check("pin a off", {7'h00, oe_a}, 8'h00);
      wr(ADDR_CTRL1, 8'h86);
      pulse(1'b1);
      rdc("alarm b off", ADDR_CTRL2, 8'h20);
      check("pin a still", {7'h00, oe_a}, 8'h00);
      wr(ADDR_CTRL1, 8'hc6);
      pulse(1'b1);
      rdc("alarm b set", ADDR_CTRL2, 8'h21);
      // Both routes to pin B, fixed-low periodic, crystal clock gated off
      wr(ADDR_CTRL2, 8'h28);
      wr(ADDR_CTRL1, 8'hf1);
      rdc("fixed low", ADDR_CTRL2, 8'h2c);
      check("pin b periodic", {7'h00, oe_b}, 8'h01);
      check("pin a unrouted", {7'h00, oe_a}, 8'h00);
      // A 1 Hz pulse is low for half of the 64-cycle second
      wr(ADDR_CTRL1, 8'hf3);
      pins(8);
      pins(64);
      check("pulse 1hz", 8'(hi_b), 8'h20);
      wr(ADDR_CTRL1, 8'hc4);
      pins(70);
      rdc("per second", ADDR_CTRL2, 8'h2c);
      check("pin a second", {7'h00, oe_a}, 8'h01);
      wr(ADDR_CTRL1, 8'hc0);
      rdc("periodic off", ADDR_CTRL2, 8'h28);
      rdc("unmapped", 4'h8, 8'h00);
      $display("test flags done");
      final_report();
   end
endmodule
